// >>> fbc_host.sv
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
module fbc_host
   import fbc_pkg::*;
#(
   parameter int WAKE_OUT_CYCLES = WAKE_OUT_CYC,
   parameter int WAKE_WR_CYCLES = WAKE_WR_CYC
) (
   input wire logic clk, // 40 MHz clock
   input wire logic reset, // async, active high
   input wire logic [3:0] reg_addr, // software register address
   input wire logic [31:0] reg_wdata, // software write data
   input wire logic reg_wr, // software write strobe
   input wire logic reg_rd, // software read strobe
   output logic [31:0] reg_rdata, // read data, cycle after strobe
   output logic [fbc_pkg::ADDR_W-1:0] flash_addr, // flash address pins
   input wire logic [fbc_pkg::DATA_W-1:0] data_bus_i, // flash data in
   output logic [fbc_pkg::DATA_W-1:0] data_bus_o, // flash data out
   output logic data_bus_oe, // high while host drives data
   output logic chip_select_n, // flash chip select
   output logic output_gate_n, // flash output gate
   output logic write_strobe_n, // flash write strobe
   output logic reset_powerdown_n, // flash reset / power-down
   output logic hv_enable, // request high_voltage_level on reset pin
   input wire logic ready_busy_n // flash ready, low while busy
);
   import fbc_pkg::*;

   // software registers, all fields ours:
   //   CTRL  bit0 go, bits 2:1 kind, bit3 reset pulse, bit4 park, bit5 hv
   //   ADDR  20-bit flash byte address
   //   WDATA first data byte on the flash bus
   //   RDATA byte taken at the end of the last read
   //   STAT  bit0 host busy, bit1 ready_busy_n, bit2 parked, bit3 wake
   //   CMD2  second byte of a two-write pair
   // writes are dropped while an operation runs; software polls STAT
   // first. the only exception is clearing the park bit, which the
   // parked state watches itself.
   // a CTRL write with reset or park set ignores go; kind is still stored.
   // kind 0 reads, kind 1 writes WDATA once, kind 2 writes WDATA then
   // CMD2 as the two-write pair that altering commands need.
   // hv_enable follows the hv bit only while the reset pin is high;
   // the flash treats the raised level as a lock override.
   // the lock itself is the flash's business, not ours.
   // read: select, 2 cycles, gate, 4 cycles, sample, release both.
   // write: select and data, 2 cycles, strobe low 3 cycles, 2 cycles
   // hold, release; a pair runs the bus cycle twice back to back.
   // reset: pin low for 5 cycles, then the wake counter runs.
   typedef enum logic [3:0] {
      S_IDLE, // pins idle, ready for software
      S_RD_SETUP, // select low, gate still high
      S_RD_WAIT, // gate low, data settling
      S_WR_SETUP, // select low, data driven
      S_WR_STROBE, // strobe low
      S_WR_HOLD, // strobe high, data still driven
      S_PD_HOLD, // reset pin low, least low time
      S_PD_PARK, // reset pin held low by software
      S_WAKE // reset pin still low; released on leaving
   } fbc_state_t;

   typedef struct packed {
      // sequencer
      fbc_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [15:0] wake_cnt;
      logic second;
      logic [1:0] kind;
      // software registers
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] cmd2;
      logic [DATA_W-1:0] rdata;
      logic park;
      logic hv;
      // read port
      logic [31:0] rd_out;
      // flash pins
      logic cs_n;
      logic oe_n;
      logic we_n;
      logic rp_n;
      logic drive;
      logic done;
   } fbc_regs_t;

   fbc_regs_t r, n;

   logic busy_host;
   logic [3:0] stat_bits;
   assign busy_host = (r.st != S_IDLE);
   // ready_busy_n is read live: the flash can finish while host idles
   assign stat_bits = {r.wake_cnt != 16'h0, r.park, ready_busy_n,
      busy_host};

   always_comb begin
      n = r;
      n.rd_out = 32'h0;
      // read data stand one cycle only, zero otherwise
      if (reg_rd) begin
         unique case (reg_addr)
            REG_ADDR: n.rd_out = {12'h000, r.addr};
            REG_WDATA: n.rd_out = {24'h000000, r.wdata};
            REG_RDATA: n.rd_out = {24'h000000, r.rdata};
            REG_CMD2: n.rd_out = {24'h000000, r.cmd2};
            REG_STAT: n.rd_out = {28'h0, stat_bits};
            REG_CTRL: n.rd_out = {26'h0, r.hv, r.park, 1'b0,
               r.kind, 1'b0};
            default: n.rd_out = 32'h0;
         endcase
      end
      // the wake guard counts in the background so status sees it
      if (r.wake_cnt != 16'h0 && r.st != S_PD_HOLD && r.st != S_PD_PARK)
         n.wake_cnt = r.wake_cnt - 16'h1;

      // software writes; a running operation must not see its
      // address or data change under it
      if (reg_wr && !busy_host) begin
         unique case (reg_addr)
            REG_ADDR: n.addr = reg_wdata[ADDR_W-1:0] & TOP_ADDR;
            REG_WDATA: n.wdata = reg_wdata[DATA_W-1:0];
            REG_CMD2: n.cmd2 = reg_wdata[DATA_W-1:0];
            REG_CTRL: begin
               n.hv = reg_wdata[CTRL_HV];
               n.kind = reg_wdata[CTRL_KIND0+1:CTRL_KIND0];
               n.park = reg_wdata[CTRL_PDOWN];
               if (reg_wdata[CTRL_RESET] || reg_wdata[CTRL_PDOWN]) begin
                  // pulse or park reset pin; aborts any flash work
                  // the reset pulse overrides go; no need to clear it
                  n.st = S_PD_HOLD;
                  n.cnt = CNT_W'(PD_CYC);
                  n.rp_n = 1'b0;
                  n.cs_n = 1'b1;
                  n.oe_n = 1'b1;
                  n.we_n = 1'b1;
                  n.drive = 1'b0;
               end else if (reg_wdata[CTRL_GO]) begin
                  n.second = 1'b0;
                  n.cnt = CNT_W'(SETUP_CYC);
                  if (reg_wdata[CTRL_KIND0+1:CTRL_KIND0] == OP_READ) begin
                     // the read waits out the output wake interval itself
                     n.st = S_RD_SETUP;
                     n.cs_n = 1'b0;
                  end else begin
                     n.st = S_WR_SETUP;
                     n.cs_n = 1'b0;
                     n.drive = 1'b1;
                  end
               end
            end
            default: ;
         endcase
      end

      // flash bus sequencer
      unique case (r.st)
         S_IDLE: ;

         // select settles before the gate opens
         S_RD_SETUP: begin
            // flash outputs are not valid until wake_to_output_time
            if (r.wake_cnt == 16'h0) begin
               n.cnt = r.cnt - CNT_W'(1);
               if (r.cnt == CNT_W'(1)) begin
                  n.oe_n = 1'b0;
                  n.cnt = CNT_W'(READ_CYC);
                  n.st = S_RD_WAIT;
               end
            end
         end

         // sample at the last gate cycle, then release both
         S_RD_WAIT: begin
            n.cnt = r.cnt - CNT_W'(1);
            if (r.cnt == CNT_W'(1)) begin
               n.rdata = data_bus_i;
               n.oe_n = 1'b1;
               n.cs_n = 1'b1;
               n.st = S_IDLE;
            end
         end

         // address and data set up before the strobe falls
         S_WR_SETUP: begin
            // hold off commands until wake_to_write_time has passed
            if (r.wake_cnt == 16'h0) begin
               n.cnt = r.cnt - CNT_W'(1);
               if (r.cnt == CNT_W'(1)) begin
                  n.we_n = 1'b0;
                  n.cnt = CNT_W'(STROBE_CYC);
                  n.st = S_WR_STROBE;
               end
            end
         end

         // strobe low; the flash latches on its rising edge
         S_WR_STROBE: begin
            n.cnt = r.cnt - CNT_W'(1);
            if (r.cnt == CNT_W'(1)) begin
               n.we_n = 1'b1;
               n.cnt = CNT_W'(SETUP_CYC);
               n.st = S_WR_HOLD;
            end
         end

         // data held past the strobe edge, then select released
         S_WR_HOLD: begin
            n.cnt = r.cnt - CNT_W'(1);
            if (r.cnt == CNT_W'(1)) begin
               n.cs_n = 1'b1;
               n.drive = 1'b0;
               if (r.kind == OP_WRITE2 && !r.second) begin
                  // second bus cycle of the pair follows directly
                  n.second = 1'b1;
                  n.cnt = CNT_W'(SETUP_CYC);
                  n.st = S_WR_SETUP;
                  n.cs_n = 1'b0;
                  n.drive = 1'b1;
               end else begin
                  n.st = S_IDLE;
               end
            end
         end

         // least low time of the reset pin
         S_PD_HOLD: begin
            n.cnt = r.cnt - CNT_W'(1);
            if (r.cnt == CNT_W'(1))
               n.st = r.park ? S_PD_PARK : S_WAKE;
         end

         // deep power-down for as long as software wants
         S_PD_PARK: begin
            // stay powered down until software clears the park bit
            if (reg_wr && reg_addr == REG_CTRL && !reg_wdata[CTRL_PDOWN]) begin
               n.park = 1'b0;
               n.st = S_WAKE;
            end
         end

         // one guard covers both wake delays; the longer one wins
         S_WAKE: begin
            n.rp_n = 1'b1;
            n.wake_cnt = 16'(WAKE_WR_CYCLES > WAKE_OUT_CYCLES ?
               WAKE_WR_CYCLES : WAKE_OUT_CYCLES);
            n.st = S_IDLE;
         end
         default: n.st = S_IDLE;
      endcase
      n.done = 1'b0;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         r <= '0;
         // reset pulses the flash reset pin for its least low time and
         // then wakes it, so the flash reads array data afterwards
         r.st <= S_PD_HOLD;
         r.cs_n <= 1'b1;
         r.oe_n <= 1'b1;
         r.we_n <= 1'b1;
         r.rp_n <= 1'b0;
         r.cnt <= CNT_W'(PD_CYC);
      end else begin
         r <= n;
      end
   end

   // select, gate, strobe, reset pin and address come straight from flip-flops; data out,
   // data enable and hv_enable pass through one gate; the data enable drops with the gate, never after it
   assign reg_rdata = r.rd_out;
   assign flash_addr = r.addr;
   assign data_bus_o = r.second ? r.cmd2 : r.wdata;
   assign data_bus_oe = r.drive & r.oe_n;
   assign chip_select_n = r.cs_n;
   assign output_gate_n = r.oe_n;
   assign write_strobe_n = r.we_n;
   assign reset_powerdown_n = r.rp_n;
   assign hv_enable = r.hv & r.rp_n;
endmodule // fbc_host

// >>> fbc_pkg.sv
package fbc_pkg;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   // software-side register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_WDATA = 4'h2;
   localparam logic [3:0] REG_RDATA = 4'h3;
   localparam logic [3:0] REG_STAT = 4'h4;
   localparam logic [3:0] REG_CMD2 = 4'h5;
   // control register fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_KIND0 = 1;
   localparam int CTRL_RESET = 3;
   localparam int CTRL_PDOWN = 4;
   localparam int CTRL_HV = 5;
   // operation kinds in CTRL[2:1]
   localparam logic [1:0] OP_READ = 2'h0;
   localparam logic [1:0] OP_WRITE1 = 2'h1;
   localparam logic [1:0] OP_WRITE2 = 2'h2;
   // status fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_RDY = 1;
   localparam int STAT_PD = 2;
   localparam int STAT_WAKE = 3;
   // block map
   localparam int BLOCK_SHIFT = 16;
   localparam logic [19:0] TOP_ADDR = 20'hFFFFF;
   localparam logic [7:0] STATUS_AFTER_WAKE = 8'h80;
   // timing
   localparam int CLK_MHZ = 40;
   localparam int PD_MIN_NS = 100;
   localparam int PD_CYC = (PD_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int SETUP_CYC = 2;
   localparam int STROBE_CYC = 3;
   localparam int READ_CYC = 4;
   localparam int WAKE_OUT_NS = 1000;
   localparam int WAKE_WR_NS = 1000;
   localparam int WAKE_OUT_CYC = WAKE_OUT_NS * CLK_MHZ / 1000;
   localparam int WAKE_WR_CYC = WAKE_WR_NS * CLK_MHZ / 1000;
   localparam int CNT_W = 8;
endpackage

// >>> fbc_host_sva.sv
`timescale 1ns/1ps
module fbc_host_chk
   import fbc_pkg::*;
#(
   parameter int WAKE_OUT_CYCLES = 4,
   parameter int WAKE_WR_CYCLES = 4
) (
   input wire logic clk, // clock
   input wire logic reset, // async reset
   input wire logic [fbc_pkg::ADDR_W-1:0] flash_addr, // address
   input wire logic [fbc_pkg::DATA_W-1:0] data_bus_o, // data out
   input wire logic data_bus_oe, // data enable
   input wire logic chip_select_n, // select
   input wire logic output_gate_n, // gate
   input wire logic write_strobe_n, // strobe
   input wire logic reset_powerdown_n // power-down
);
   logic [7:0] wk_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // cycles since the flash left power-down, saturating
   always_ff @(posedge clk or posedge reset) begin
      if (reset) wk_r <= 8'h00;
      else if (!reset_powerdown_n) wk_r <= 8'h00;
      else if (wk_r != 8'hFF) wk_r <= wk_r + 8'h01;
   end
   chk_read_pins: assert property (!output_gate_n |-> !chip_select_n
      && write_strobe_n && reset_powerdown_n) else $error("bad read pins");
   chk_bus_turn: assert property (data_bus_oe |-> output_gate_n)
      else $error("host drives bus while gate low");
   chk_write_pins: assert property (!write_strobe_n |-> !chip_select_n
      && output_gate_n && data_bus_oe) else $error("bad write pins");
   chk_strobe_len: assert property ($fell(write_strobe_n) |->
      !write_strobe_n[*3] ##1 write_strobe_n) else $error("strobe length");
   chk_latch_hold: assert property ($rose(write_strobe_n) |->
      !chip_select_n && data_bus_oe && $stable(flash_addr)
      && $stable(data_bus_o)) else $error("write ended unstable");
   chk_no_wr_pd: assert property (!reset_powerdown_n |-> write_strobe_n)
      else $error("write during power-down");
   chk_pd_min: assert property ($fell(reset_powerdown_n) |->
      !reset_powerdown_n[*4]) else $error("power-down too short");
   chk_wake_write: assert property ($fell(write_strobe_n) |->
      wk_r >= WAKE_WR_CYCLES) else $error("write too soon after wake");
   chk_wake_read: assert property ($fell(output_gate_n) |->
      wk_r >= WAKE_OUT_CYCLES) else $error("read too soon after wake");
   cover property ($fell(reset_powerdown_n));
   cover property ($fell(output_gate_n));
   cover property ($rose(write_strobe_n));
endmodule // fbc_host_chk
bind fbc_host fbc_host_chk #(.WAKE_OUT_CYCLES(WAKE_OUT_CYCLES),
   .WAKE_WR_CYCLES(WAKE_WR_CYCLES)) u_chk (.clk, .reset, .flash_addr,
   .data_bus_o, .data_bus_oe, .chip_select_n, .output_gate_n,
   .write_strobe_n, .reset_powerdown_n);

// >>> fbc_flash_model.sv
`timescale 1ns/1ps
module fbc_flash_model #(
   parameter logic [7:0] PROG_CMD = 8'h40,
   parameter logic [3:0] LOCKED_BLK = 4'hF,
   parameter int BUSY_NS = 2000
) (
   input wire logic [19:0] flash_addr, // address
   input wire logic [7:0] dq_i, // resolved bus
   input wire logic chip_select_n, // select
   input wire logic output_gate_n, // gate
   input wire logic write_strobe_n, // strobe
   input wire logic reset_powerdown_n, // power-down
   input wire logic hv_enable, // lock override
   output logic [7:0] dq_o, // read data
   output logic dq_en, // driving bus
   output logic ready_busy_n // low while busy
);
   logic [7:0] mem [logic [19:0]];
   logic [19:0] pa;
   logic [7:0] pd;
   logic armed = 1'b0;
   initial ready_busy_n = 1'b1;
   assign dq_en = !chip_select_n && !output_gate_n && reset_powerdown_n;
   // supply levels, identifier mode and suspend
   // are not modelled; reads never depend on the program supply
   // no mode command needed: always read array
   assign dq_o = mem.exists(flash_addr) ? mem[flash_addr] : 8'hFF;
   // only the first rising edge ends the write
   always @(posedge write_strobe_n or posedge chip_select_n) begin
      if ((write_strobe_n ^ chip_select_n) && reset_powerdown_n) begin
         if (!armed) armed = (dq_i == PROG_CMD);
         else begin
            armed = 1'b0;
            if (hv_enable || flash_addr[19:16] != LOCKED_BLK) begin
               pa = flash_addr;
               pd = dq_i;
               ready_busy_n = 1'b0;
            end
         end
      end
   end
   always @(negedge reset_powerdown_n) armed = 1'b0;
   // runs on whatever the select does
   always begin
      wait (!ready_busy_n);
      fork
         #BUSY_NS;
         wait (!reset_powerdown_n);
      join_any
      disable fork;
      if (reset_powerdown_n) mem[pa] = pd;
      else begin
         mem[pa] = ~pd;
         wait (reset_powerdown_n);
      end
      ready_busy_n = 1'b1;
   end
endmodule // fbc_flash_model

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
   import fbc_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, v;
   logic [19:0] flash_addr;
   logic [7:0] data_bus_o, data_bus_i, dq_o;
   logic [7:0] last_r = 8'h00;
   logic data_bus_oe, chip_select_n, output_gate_n, write_strobe_n;
   logic reset_powerdown_n, hv_enable, ready_busy_n, dq_en;
   int n_fail = 0;
   int checked = 0;
   logic [19:0] r_addr [4] = '{20'h00000, 20'h7FFFF, 20'hFFFFF, 20'hF1234};
   logic [7:0] r_data [4] = '{8'h3C, 8'hA5, 8'h5A, 8'h96};
   logic r_hv [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
   logic [7:0] r_exp [4] = '{8'h3C, 8'hA5, 8'hFF, 8'h96};
   always #12.5 clk = ~clk;
   // a released bus must not keep its last value
   always @(posedge clk) last_r <= data_bus_i;
   assign data_bus_i = data_bus_oe ? data_bus_o : dq_en ? dq_o : ~last_r;
   fbc_host #(.WAKE_OUT_CYCLES(4), .WAKE_WR_CYCLES(4)) u_dut (.clk, .reset,
      .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flash_addr,
      .data_bus_i, .data_bus_o, .data_bus_oe, .chip_select_n, .output_gate_n,
      .write_strobe_n, .reset_powerdown_n, .hv_enable, .ready_busy_n);
   fbc_flash_model u_flash (.flash_addr, .dq_i(data_bus_i), .chip_select_n,
      .output_gate_n, .write_strobe_n, .reset_powerdown_n, .hv_enable, .dq_o,
      .dq_en, .ready_busy_n);
   task automatic report_and_stop();
      $display("checks %0d fails %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic wait_stat(input logic [1:0] want);
      for (int i = 0; i < 400; i++) begin
         rd(REG_STAT);
         if (v[1:0] === want) return;
      end
      n_fail++;
      report_and_stop();
   endtask
   task automatic prog(input logic [19:0] a, input logic [7:0] d, input logic hv);
      wr(REG_ADDR, {12'h000, a});
      wr(REG_WDATA, 32'h40);
      wr(REG_CMD2, {24'h0, d});
      wr(REG_CTRL, {26'h0, hv, 5'h05});
   endtask
   task automatic read_at(input logic [19:0] a);
      wr(REG_ADDR, {12'h000, a});
      wr(REG_CTRL, 32'h1);
      wait_stat(2'b10);
      rd(REG_RDATA);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      wait_stat(2'b10);
      read_at(20'h00000);
      chk(v[7:0], 8'hFF);
      $display("wake read done");
      for (int i = 0; i < 4; i++) begin
         prog(r_addr[i], r_data[i], r_hv[i]);
         wait_stat(2'b10);
         read_at(r_addr[i]);
         chk(v[7:0], r_exp[i]);
      end
      $display("rows done");
      wr(REG_ADDR, 32'h10000);
      wr(REG_WDATA, 32'h0);
      wr(REG_CTRL, 32'h3);
      wait_stat(2'b10);
      wr(4'hF, 32'h55);
      read_at(20'h10000);
      chk(v[7:0], 8'hFF);
      rd(REG_ADDR);
      chk(v[23:16], 8'h01);
      $display("stray write done");
      wr(REG_CTRL, 32'h10);
      rd(REG_STAT);
      chk(v[7:0] & 8'h04, 8'h04);
      chk({7'h0, reset_powerdown_n}, 8'h00);
      repeat (4) @(posedge clk);
      wr(REG_CTRL, 32'h0);
      read_at(20'h7FFFF);
      chk(v[7:0], 8'hA5);
      $display("power-down done");
      prog(20'h00010, 8'h77, 1'b0);
      wait_stat(2'b00);
      chk({7'h0, ready_busy_n}, 8'h00);
      wr(REG_CTRL, 32'h8);
      wait_stat(2'b10);
      read_at(20'h00010);
      chk(v[7:0], 8'h88);
      $display("abort done");
      report_and_stop();
   end
endmodule // testbench
